// >>> logic/sbl_pkg.sv
package sbl_pkg;

  // ------------------------------------------------------------
  // Memory map
  // ------------------------------------------------------------
  localparam logic [31:0] BOOT_ROM_BASE = 32'h0000_0000;
  localparam logic [31:0] BOOT_ROM_LAST = 32'h0000_0fff;
  localparam logic [31:0] FLASH_BASE_NORMAL = 32'h0000_0000;
  localparam logic [31:0] FLASH_BASE_BOOT = 32'h3f80_0000;
  localparam logic [31:0] RAM_BASE = 32'h2000_0000;
  localparam logic [31:0] RAM_WORK_LAST = 32'h2000_03ff;
  localparam logic [31:0] RAM_LOAD_FIRST = 32'h2000_0400;
  localparam logic [31:0] RAM_LAST_DEFAULT = 32'h2000_7fff;
  localparam logic [31:0] ID_AREA_FIRST = 32'h3f87_fff0;

  // ------------------------------------------------------------
  // Protocol codes
  // ------------------------------------------------------------
  localparam logic [7:0] MODE_ASYNC = 8'h86;
  localparam logic [7:0] MODE_SYNC = 8'h30;
  localparam logic [7:0] CMD_RAM_LOAD = 8'h10;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h40;
  localparam logic [3:0] NAK_NIBBLE = 4'h1;
  localparam logic [3:0] COMM_ERR_NIBBLE = 4'h8;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int PASSWORD_BYTES = 12;
  localparam int HEADER_BYTES = 6;
  localparam int UART_DATA_BITS = 8;
  localparam int BAUD_OVERSAMPLE = 16;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic {
    SBL_LINK_ASYNC,
    SBL_LINK_SYNC
  } sbl_link_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] data;
    logic we;
  } sbl_ram_wr_t;

  typedef struct packed {
    logic boot_mode;
    logic [31:0] boot_rom_base;
    logic [31:0] flash_base;
    logic [31:0] pc;
    logic run;
  } sbl_map_t;

endpackage

// >>> logic/sbl_loader.sv
// Operation
// - Boot pin low at reset release starts execution from internal boot ROM.
// - Boot mode maps ROM to lowest 4 KB, flash moved to high base.
// - Twelve received password bytes are compared with stored flash bytes.
// - Erased password block means every expected byte equals 0xff.
// - Password mismatch aborts the transfer; nothing is written to RAM.
// - Routine lands from first free RAM address to RAM end; work area kept.
// - Successful download hands execution to the routine in RAM.
// - Async link is half-duplex, LSB first, 8 data bits, no parity, 1 stop.
// - Sync link is full-duplex, LSB first, host supplies the shift clock.
// - Sync link drives a handshake output pin to pace the host.
// - Command 0x10 is RAM transfer, 0x40 is chip and protection erase.
// - Top sixteen flash bytes hold ID and password data.
// - Async host rate is accepted only if the mode-byte low run exceeds 16 clocks; sync runs on the host clock.
// - Normal boot maps flash normally and runs the application.
// - First byte picks link mode and rate; device echoes it.
// - Command echoed; negative reply low nibble 1, comm error nibble 8.
module sbl_loader #(
  parameter logic [31:0] RAM_LAST = sbl_pkg::RAM_LAST_DEFAULT
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_SHIFT_CLK,
  input wire logic I_BOOT_SELECT_PORT_PIN,
  input wire logic I_SERIAL_RECEIVE_LINE,
  input wire logic [7:0] I_PASSWORD_BYTE,
  output logic O_SERIAL_TRANSMIT_LINE,
  output logic O_HANDSHAKE_OUT_PIN,
  output logic [3:0] O_PASSWORD_INDEX,
  output sbl_pkg::sbl_ram_wr_t O_RAM_WR,
  output sbl_pkg::sbl_map_t O_MAP,
  output logic O_ERASE_REQ
);

  initial begin
    if (RAM_LAST < sbl_pkg::RAM_LOAD_FIRST) begin
      $error("RAM_LAST below first load address");
    end
  end

  // ------------------------------------------------------------
  // Shift-clock domain: sync receiver and transmitter
  // ------------------------------------------------------------
  // Host clock may stop between bytes; each byte is handed over by toggle.
  typedef struct packed {
    logic [2:0] rx_cnt;
    logic [7:0] rx_sh;
    logic [7:0] rx_byte;
    logic rx_tgl;
    logic [7:0] tx_sh;
  } sbl_lk_t;
  sbl_lk_t lk, next_lk;
  // Reply byte, held steady while the handshake pin is high
  logic [7:0] tx_hold_x;

  // Receive line moves with the shift clock, so it needs no synchroniser
  always_comb begin
    next_lk = lk;
    next_lk.rx_sh = {I_SERIAL_RECEIVE_LINE, lk.rx_sh[7:1]};
    next_lk.tx_sh = {1'b1, lk.tx_sh[7:1]};
    next_lk.rx_cnt = lk.rx_cnt + 3'h1;
    if (lk.rx_cnt == 3'h7) begin
      next_lk.rx_byte = {I_SERIAL_RECEIVE_LINE, lk.rx_sh[7:1]};
      next_lk.rx_tgl = ~lk.rx_tgl;
      next_lk.tx_sh = tx_hold_x;
    end
  end

  always_ff @(posedge I_SHIFT_CLK) begin
    if (I_RST) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ------------------------------------------------------------
  // System domain
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    S_STRAP,
    S_NORMAL,
    S_MODE,
    S_CMD,
    S_PASS,
    S_PSUM,
    S_HDR,
    S_HSUM,
    S_DATA,
    S_DSUM,
    S_TX,
    S_RUN,
    S_HALT
  } sbl_state_t;

  typedef struct packed {
    logic [1:0] pin_s;
    logic [1:0] rxd_s;
    logic [2:0] tgl_s;
    logic [7:0] tx_hold;
    sbl_state_t state;
    sbl_state_t after_tx;
    sbl_pkg::sbl_link_t link;
    logic [15:0] bit_len;
    logic [15:0] cnt;
    logic [3:0] bitn;
    logic rx_busy;
    logic [8:0] tx_sh;
    logic tx_busy;
    logic [7:0] rx_byte;
    logic rx_stb;
    logic [3:0] idx;
    logic [7:0] sum;
    logic pass_bad;
    logic [47:0] hdr;
    logic [15:0] left;
    logic [31:0] waddr;
    logic sync_tx_req;
    logic txd;
    logic hs;
    sbl_pkg::sbl_ram_wr_t ram;
    sbl_pkg::sbl_map_t map;
    logic erase;
  } sbl_st_t;
  sbl_st_t st, next_st;

  assign tx_hold_x = st.tx_hold;

  logic [7:0] ack_byte;
  logic [7:0] rcv;
  logic [31:0] hdr_addr;
  logic [15:0] hdr_count;
  logic [31:0] hdr_end;

  always_comb begin
    ack_byte = '0;
    rcv = st.rx_byte;
    hdr_addr = st.hdr[47:16];
    hdr_count = st.hdr[15:0];
    hdr_end = hdr_addr + {16'h0, hdr_count} - 32'h1;
    next_st = st;
    next_st.pin_s = {st.pin_s[0], I_BOOT_SELECT_PORT_PIN};
    next_st.rxd_s = {st.rxd_s[0], I_SERIAL_RECEIVE_LINE};
    next_st.tgl_s = {st.tgl_s[1:0], lk.rx_tgl};
    next_st.rx_stb = 1'b0;
    next_st.ram.we = 1'b0;
    next_st.erase = 1'b0;

    // Async receiver, 8N1 LSB first at the measured bit length
    if (st.link == sbl_pkg::SBL_LINK_ASYNC && st.state != S_MODE) begin
      if (!st.rx_busy) begin
        if (!st.rxd_s[1] && !st.tx_busy) begin
          next_st.rx_busy = 1'b1;
          next_st.cnt = {1'b0, st.bit_len[15:1]};
          next_st.bitn = '0;
        end
      end else if (st.cnt != 16'h0) begin
        next_st.cnt = st.cnt - 16'h1;
      end else begin
        next_st.cnt = st.bit_len;
        next_st.bitn = st.bitn + 4'h1;
        if (st.bitn != 4'h0 && st.bitn <= 4'(sbl_pkg::UART_DATA_BITS)) begin
          next_st.rx_byte = {st.rxd_s[1], st.rx_byte[7:1]};
        end
        if (st.bitn == 4'(sbl_pkg::UART_DATA_BITS + 1)) begin
          next_st.rx_busy = 1'b0;
          next_st.rx_stb = st.rxd_s[1];
        end
      end
    end else if (st.link == sbl_pkg::SBL_LINK_SYNC && (st.tgl_s[2] ^ st.tgl_s[1])) begin
      next_st.rx_byte = lk.rx_byte;
      next_st.rx_stb = 1'b1;
    end

    // Async transmitter shares the line half-duplex
    if (st.tx_busy) begin
      if (st.cnt != 16'h0) begin
        next_st.cnt = st.cnt - 16'h1;
      end else begin
        next_st.cnt = st.bit_len;
        next_st.txd = st.tx_sh[0];
        next_st.tx_sh = {1'b1, st.tx_sh[8:1]};
        next_st.bitn = st.bitn + 4'h1;
        if (st.bitn == 4'(sbl_pkg::UART_DATA_BITS + 1)) begin
          next_st.tx_busy = 1'b0;
          next_st.state = st.after_tx;
        end
      end
    end

    unique case (st.state)
      S_STRAP: begin
        // Wait out the pin synchroniser before deciding
        next_st.cnt = st.cnt + 16'h1;
        if (st.cnt == 16'($bits(st.pin_s))) begin
          next_st.cnt = '0;
          if (st.pin_s[1]) begin
            next_st.state = S_NORMAL;
          end else begin
            next_st.state = S_MODE;
          end
        end
      end
      S_NORMAL: begin
        next_st.map.boot_mode = 1'b0;
        next_st.map.flash_base = sbl_pkg::FLASH_BASE_NORMAL;
        next_st.map.pc = sbl_pkg::FLASH_BASE_NORMAL;
        next_st.map.run = 1'b1;
      end
      S_MODE: begin
        next_st.map.boot_mode = 1'b1;
        next_st.map.boot_rom_base = sbl_pkg::BOOT_ROM_BASE;
        next_st.map.flash_base = sbl_pkg::FLASH_BASE_BOOT;
        next_st.map.pc = sbl_pkg::BOOT_ROM_BASE;
        // Low run of start bit and bit 0 of the 0x86 byte measures the host rate
        if (!st.rxd_s[1]) begin
          next_st.cnt = st.cnt + 16'h1;
          next_st.rx_busy = 1'b1;
        end else if (st.rx_busy) begin
          next_st.rx_busy = 1'b0;
          next_st.cnt = '0;
          // Short lows are sync-mode data, not a start bit
          if (st.cnt > 16'(sbl_pkg::BAUD_OVERSAMPLE)) begin
            // Low run of the mode byte spans two bit times
            next_st.bit_len = {1'b0, st.cnt[15:1]} - 16'h1;
            next_st.link = sbl_pkg::SBL_LINK_ASYNC;
            next_st.tx_hold = sbl_pkg::MODE_ASYNC;
            next_st.state = S_TX;
            next_st.after_tx = S_CMD;
          end
        end
        if (st.tgl_s[2] ^ st.tgl_s[1]) begin
          next_st.link = sbl_pkg::SBL_LINK_SYNC;
          if (lk.rx_byte == sbl_pkg::MODE_SYNC) begin
            next_st.tx_hold = sbl_pkg::MODE_SYNC;
            next_st.state = S_TX;
            next_st.after_tx = S_CMD;
          end
        end
      end
      S_CMD: begin
        if (st.rx_stb) begin
          next_st.idx = '0;
          next_st.sum = '0;
          next_st.pass_bad = 1'b0;
          next_st.state = S_TX;
          if (rcv == sbl_pkg::CMD_RAM_LOAD) begin
            next_st.tx_hold = rcv;
            next_st.after_tx = S_PASS;
          end else if (rcv == sbl_pkg::CMD_CHIP_ERASE) begin
            next_st.tx_hold = rcv;
            next_st.erase = 1'b1;
            next_st.after_tx = S_CMD;
          end else begin
            next_st.tx_hold = {rcv[7:4], sbl_pkg::NAK_NIBBLE};
            next_st.after_tx = S_CMD;
          end
        end
      end
      S_PASS: begin
        // Stored bytes sit in the ID area; blank flash reads all 0xff
        if (st.rx_stb) begin
          next_st.sum = st.sum + rcv;
          next_st.pass_bad = st.pass_bad | (rcv != I_PASSWORD_BYTE);
          next_st.idx = st.idx + 4'h1;
          if (st.idx == 4'(sbl_pkg::PASSWORD_BYTES - 1)) begin
            next_st.state = S_PSUM;
            next_st.idx = '0;
          end
        end
      end
      S_PSUM: begin
        if (st.rx_stb) begin
          next_st.state = S_TX;
          next_st.idx = '0;
          if (rcv != 8'(-st.sum)) begin
            next_st.tx_hold = {sbl_pkg::CMD_RAM_LOAD[7:4], sbl_pkg::COMM_ERR_NIBBLE};
            next_st.after_tx = S_CMD;
          end else if (st.pass_bad) begin
            // Mismatch never reaches the data phase
            next_st.tx_hold = {sbl_pkg::CMD_RAM_LOAD[7:4], sbl_pkg::NAK_NIBBLE};
            next_st.after_tx = S_CMD;
          end else begin
            next_st.tx_hold = sbl_pkg::CMD_RAM_LOAD;
            next_st.after_tx = S_HDR;
            next_st.sum = '0;
          end
        end
      end
      S_HDR: begin
        if (st.rx_stb) begin
          next_st.hdr = {st.hdr[39:0], rcv};
          next_st.sum = st.sum + rcv;
          next_st.idx = st.idx + 4'h1;
          if (st.idx == 4'(sbl_pkg::HEADER_BYTES - 1)) begin
            next_st.state = S_HSUM;
          end
        end
      end
      S_HSUM: begin
        if (st.rx_stb) begin
          next_st.state = S_TX;
          next_st.after_tx = S_CMD;
          next_st.waddr = hdr_addr;
          next_st.left = hdr_count;
          if (rcv != 8'(-st.sum)) begin
            next_st.tx_hold = {sbl_pkg::CMD_RAM_LOAD[7:4], sbl_pkg::COMM_ERR_NIBBLE};
          end else if (hdr_addr < sbl_pkg::RAM_LOAD_FIRST || hdr_count == 16'h0
                       || hdr_end > RAM_LAST) begin
            next_st.tx_hold = {sbl_pkg::CMD_RAM_LOAD[7:4], sbl_pkg::NAK_NIBBLE};
          end else begin
            next_st.tx_hold = sbl_pkg::CMD_RAM_LOAD;
            next_st.after_tx = S_DATA;
            next_st.sum = '0;
          end
        end
      end
      S_DATA: begin
        if (st.rx_stb) begin
          next_st.ram.addr = st.waddr;
          next_st.ram.data = rcv;
          next_st.ram.we = 1'b1;
          next_st.waddr = st.waddr + 32'h1;
          next_st.sum = st.sum + rcv;
          next_st.left = st.left - 16'h1;
          if (st.left == 16'h1) begin
            next_st.state = S_DSUM;
          end
        end
      end
      S_DSUM: begin
        if (st.rx_stb) begin
          next_st.state = S_TX;
          if (rcv == 8'(-st.sum)) begin
            next_st.tx_hold = sbl_pkg::CMD_RAM_LOAD;
            next_st.after_tx = S_RUN;
          end else begin
            next_st.tx_hold = {sbl_pkg::CMD_RAM_LOAD[7:4], sbl_pkg::COMM_ERR_NIBBLE};
            next_st.after_tx = S_CMD;
          end
        end
      end
      S_TX: begin
        if (st.link == sbl_pkg::SBL_LINK_SYNC) begin
          // Shift domain picks tx_hold up at its next byte boundary
          next_st.hs = 1'b1;
          next_st.sync_tx_req = 1'b1;
          if (st.sync_tx_req && (st.tgl_s[2] ^ st.tgl_s[1])) begin
            next_st.hs = 1'b0;
            next_st.sync_tx_req = 1'b0;
            next_st.state = st.after_tx;
          end
        end else if (!st.tx_busy && !st.rx_busy) begin
          next_st.tx_sh = {st.tx_hold, 1'b0};
          next_st.tx_busy = 1'b1;
          next_st.cnt = '0;
          next_st.bitn = '0;
          next_st.state = S_HALT;
        end
      end
      S_HALT: begin
        // Transmitter moves on to after_tx at the stop bit
        next_st.hs = 1'b0;
      end
      S_RUN: begin
        next_st.map.pc = hdr_addr;
        next_st.map.run = 1'b1;
      end
      default: begin
        next_st.state = S_STRAP;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      st <= '{state: S_STRAP, after_tx: S_CMD, link: sbl_pkg::SBL_LINK_ASYNC,
              pin_s: 2'h3, rxd_s: 2'h3, txd: 1'b1, tx_sh: 9'h1ff, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign O_SERIAL_TRANSMIT_LINE = (st.link == sbl_pkg::SBL_LINK_SYNC) ? lk.tx_sh[0] : st.txd;
  assign O_HANDSHAKE_OUT_PIN = st.hs;
  assign O_PASSWORD_INDEX = st.idx;
  assign O_RAM_WR = st.ram;
  assign O_MAP = st.map;
  assign O_ERASE_REQ = st.erase;

endmodule // sbl_loader

// >>> verif/sbl_loader_properties.sv
module sbl_loader_properties #(
  parameter logic [31:0] RAM_LAST = sbl_pkg::RAM_LAST_DEFAULT
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_SHIFT_CLK,
  input wire logic I_BOOT_SELECT_PORT_PIN,
  input wire logic I_SERIAL_RECEIVE_LINE,
  input wire logic [7:0] I_PASSWORD_BYTE,
  input wire logic O_SERIAL_TRANSMIT_LINE,
  input wire logic O_HANDSHAKE_OUT_PIN,
  input wire logic [3:0] O_PASSWORD_INDEX,
  input wire sbl_pkg::sbl_ram_wr_t O_RAM_WR,
  input wire sbl_pkg::sbl_map_t O_MAP,
  input wire logic O_ERASE_REQ
);
  // ----------------------------------------
  // Boot and load checks
  // ----------------------------------------
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);

  // Pin held four cycles: synchroniser has settled
  sequence s_serial_release;
    $fell(I_RST) ##0 !I_BOOT_SELECT_PORT_PIN [*4];
  endsequence
  sequence s_normal_release;
    $fell(I_RST) ##0 I_BOOT_SELECT_PORT_PIN [*4];
  endsequence
  sequence s_wr_beat;
    O_RAM_WR.we ##1 !O_RAM_WR.we [*3];
  endsequence
  sequence s_erase_beat;
    O_ERASE_REQ ##1 !O_ERASE_REQ;
  endsequence

  a_serial_boot_entry: assert property (
    s_serial_release |-> ##[0:6] O_MAP.boot_mode) else $error("serial boot not entered");
  a_normal_boot_entry: assert property (
    s_normal_release |-> ##[0:6] (O_MAP.run && !O_MAP.boot_mode && O_MAP.pc == 32'h0
      && O_MAP.flash_base == sbl_pkg::FLASH_BASE_NORMAL)) else $error("normal boot wrong");
  a_boot_map: assert property (
    O_MAP.boot_mode |-> O_MAP.flash_base == sbl_pkg::FLASH_BASE_BOOT
      && O_MAP.boot_rom_base == sbl_pkg::BOOT_ROM_BASE) else $error("boot map wrong");
  a_wr_range: assert property (
    O_RAM_WR.we |-> O_MAP.boot_mode && O_RAM_WR.addr >= sbl_pkg::RAM_LOAD_FIRST
      && O_RAM_WR.addr <= RAM_LAST) else $error("ram write out of range");
  a_wr_single: assert property (
    O_RAM_WR.we |-> s_wr_beat) else $error("ram write not single");
  a_erase_pulse: assert property (
    O_ERASE_REQ |-> s_erase_beat) else $error("erase pulse too long");
  a_run_holds: assert property (
    O_MAP.run |=> O_MAP.run && $stable(O_MAP.pc) && $stable(O_MAP.boot_mode))
    else $error("run state changed");
  a_ram_entry: assert property (
    O_MAP.run && O_MAP.boot_mode |-> O_MAP.pc >= sbl_pkg::RAM_LOAD_FIRST
      && O_MAP.pc <= RAM_LAST) else $error("jump outside ram");
  a_quiet_after_run: assert property (
    O_MAP.run |-> !O_RAM_WR.we && !O_ERASE_REQ) else $error("activity after jump");
  a_pw_index: assert property (
    O_PASSWORD_INDEX <= 4'hb) else $error("password index past end");
  a_tx_idle: assert property (
    $fell(I_RST) |-> O_SERIAL_TRANSMIT_LINE) else $error("tx not idle after reset");
endmodule // sbl_loader_properties

bind sbl_loader sbl_loader_properties #(.RAM_LAST(RAM_LAST)) u_props (
  .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_SHIFT_CLK(I_SHIFT_CLK),
  .I_BOOT_SELECT_PORT_PIN(I_BOOT_SELECT_PORT_PIN), .I_SERIAL_RECEIVE_LINE(I_SERIAL_RECEIVE_LINE),
  .I_PASSWORD_BYTE(I_PASSWORD_BYTE), .O_SERIAL_TRANSMIT_LINE(O_SERIAL_TRANSMIT_LINE),
  .O_HANDSHAKE_OUT_PIN(O_HANDSHAKE_OUT_PIN), .O_PASSWORD_INDEX(O_PASSWORD_INDEX),
  .O_RAM_WR(O_RAM_WR), .O_MAP(O_MAP), .O_ERASE_REQ(O_ERASE_REQ)
);

// >>> verif/sbl_host.sv
module sbl_host (
  input wire logic i_clk,
  input wire logic i_tx,
  input wire logic i_hs,
  output logic o_rx,
  output logic o_sclk
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Programming host
  // ----------------------------------------
  int bit_cyc = 20;

  // Shift clock stands still low between frames
  initial begin
    o_rx = 1'b1;
    o_sclk = 1'b0;
  end

  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rx = f[i];
      repeat (bit_cyc) @(negedge i_clk);
    end
  endtask

  // Runs beside send, so a reply starting early is not missed
  task automatic recv(output logic [7:0] b);
    int n;
    n = 0;
    b = 'x;
    while (i_tx !== 1'b0 && n < 20000) begin
      @(negedge i_clk);
      n++;
    end
    if (n < 20000) begin
      repeat (bit_cyc / 2) @(negedge i_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(negedge i_clk);
        b[i] = i_tx;
      end
      repeat (bit_cyc) @(negedge i_clk);
    end
  endtask

  // One shift-clock pulse, so the shift logic sees reset
  task automatic pulse;
    #2 o_sclk = 1'b1;
    #3 o_sclk = 1'b0;
  endtask

  // Six ns shift period; reply taken just before each rising edge
  // Reply leaves on the byte after the one that loads it
  task automatic sync_xfer(input logic [7:0] b, output logic [7:0] r);
    int n;
    n = 0;
    r = 'x;
    for (int i = 0; i < 8; i++) begin
      o_rx = b[i];
      #2 o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
      #1;
    end
    o_rx = 1'b1;
    while (i_hs !== 1'b1 && n < 20000) begin
      @(negedge i_clk);
      n++;
    end
    if (n < 20000) for (int i = 0; i < 16; i++) begin
      #2 r[i % 8] = i_tx;
      o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
      #1;
    end
  endtask
endmodule // sbl_host

// >>> verif/sbl_loader_tb.sv
module sbl_loader_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic boot = 1'b1;
  logic rx, sclk, tx, hs, erase;
  logic [3:0] pidx;
  logic [7:0] r8;
  logic [7:0] pw [16];
  sbl_pkg::sbl_ram_wr_t wr;
  sbl_pkg::sbl_map_t map;
  logic [39:0] got_q [$];
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int erase_n = 0;
  int seed = 32'h53169776;

  always #25 clk = ~clk;

  sbl_loader uut (
    .I_REF_CLK(clk), .I_RST(rst), .I_SHIFT_CLK(sclk), .I_BOOT_SELECT_PORT_PIN(boot),
    .I_SERIAL_RECEIVE_LINE(rx), .I_PASSWORD_BYTE(pw[pidx]), .O_SERIAL_TRANSMIT_LINE(tx),
    .O_HANDSHAKE_OUT_PIN(hs), .O_PASSWORD_INDEX(pidx), .O_RAM_WR(wr), .O_MAP(map),
    .O_ERASE_REQ(erase)
  );
  sbl_host host (.i_clk(clk), .i_tx(tx), .i_hs(hs), .o_rx(rx), .o_sclk(sclk));

  // ----------------------------------------
  // Monitors and verdict
  // ----------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (wr.we === 1'b1) got_q.push_back({wr.addr, wr.data});
    if (erase === 1'b1) erase_n++;
    if (cycles == 60000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done;
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] b, input logic [7:0] exp);
    logic [7:0] r;
    fork
      host.send(b);
      host.recv(r);
    join
    chk({32'h0, r}, {32'h0, exp});
  endtask

  function automatic logic [7:0] csum(input logic [7:0] q [$]);
    logic [7:0] s = 8'h00;
    foreach (q[i]) s += q[i];
    return -s;
  endfunction

  // Bytes of a group go out back to back; only the checksum is answered
  task automatic grp(input logic [7:0] q [$], input logic [7:0] bias, input logic [7:0] exp);
    foreach (q[i]) host.send(q[i]);
    xfer(csum(q) + bias, exp);
  endtask

  // Mode 0 good, 1 wrong password, 2 bad checksum
  task automatic ram_cmd(input int mode, input logic [31:0] addr, input logic [15:0] cnt,
                         input logic [7:0] hdr_ack);
    logic [7:0] q [$];
    got_q.delete();
    xfer(sbl_pkg::CMD_RAM_LOAD, sbl_pkg::CMD_RAM_LOAD);
    for (int i = 0; i < sbl_pkg::PASSWORD_BYTES; i++) q.push_back(pw[i]);
    if (mode == 1) q[11] = ~q[11];
    grp(q, (mode == 2) ? 8'h01 : 8'h00, (mode == 2) ? 8'h18 : (mode == 1) ? 8'h11 : 8'h10);
    if (mode != 0) begin
      chk(40'(got_q.size()), 40'h0);
      return;
    end
    q = {addr[31:24], addr[23:16], addr[15:8], addr[7:0], cnt[15:8], cnt[7:0]};
    grp(q, 8'h00, hdr_ack);
    if (hdr_ack != 8'h10) return;
    q.delete();
    repeat (cnt) q.push_back(8'($random(seed)));
    grp(q, 8'h00, 8'h10);
    chk(40'(got_q.size()), 40'(cnt));
    foreach (q[i]) chk(got_q[i], {addr + 32'(i), q[i]});
    chk({7'h0, map.run, map.pc}, {8'h01, addr});
  endtask

  task automatic do_reset(input logic pin);
    boot = pin;
    rst = 1'b1;
    host.bit_cyc = 16 + ($unsigned($random(seed)) % 16);
    repeat (20) @(negedge clk);
    host.pulse();
    @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    foreach (pw[i]) pw[i] = 8'($random(seed));
    do_reset(1'b1);
    chk({7'h0, map.run, map.pc}, 40'h01_0000_0000);
    chk({7'h0, map.boot_mode, map.flash_base}, 40'h0);
    do_reset(1'b0);
    chk({7'h0, map.boot_mode, map.flash_base}, {8'h01, sbl_pkg::FLASH_BASE_BOOT});
    chk({8'h0, map.boot_rom_base}, 40'h0);
    xfer(sbl_pkg::MODE_ASYNC, sbl_pkg::MODE_ASYNC);
    xfer(sbl_pkg::CMD_CHIP_ERASE, sbl_pkg::CMD_CHIP_ERASE);
    chk(40'(erase_n), 40'h1);
    xfer(8'h55, 8'h51);
    ram_cmd(1, 32'h0, 16'h0, 8'h0);
    ram_cmd(2, 32'h0, 16'h0, 8'h0);
    ram_cmd(0, sbl_pkg::RAM_WORK_LAST, 16'h1, 8'h11);
    ram_cmd(0, sbl_pkg::RAM_LOAD_FIRST + 32'($unsigned($random(seed)) % 64),
            16'(1 + $unsigned($random(seed)) % 6), 8'h10);
    foreach (pw[i]) pw[i] = sbl_pkg::ERASED_BYTE;
    do_reset(1'b0);
    xfer(sbl_pkg::MODE_ASYNC, sbl_pkg::MODE_ASYNC);
    ram_cmd(0, sbl_pkg::RAM_LOAD_FIRST, 16'h1, 8'h10);
    do_reset(1'b0);
    host.sync_xfer(sbl_pkg::MODE_SYNC, r8);
    chk({32'h0, r8}, {32'h0, sbl_pkg::MODE_SYNC});
    test_done();
  end
endmodule // sbl_loader_tb
